// *** include/code_protect_map.vh ***
/*
 Constants for the program memory protection block: block address ranges,
 protection bit indices, ID range, debugger reservations, reset values.
 Assumes 21-bit program addresses and 8-bit data.
*/
`ifndef CODE_PROTECT_MAP_VH
`define CODE_PROTECT_MAP_VH

`define ADDR_W            21
`define NBLK              5
`define BLK_BOOT          3'h0
`define BOOT_END          21'h0007ff
`define BLK0_END          21'h001fff
`define BLK1_END          21'h003fff
`define BLK2_END          21'h005fff
`define BLK3_END          21'h007fff
`define BLK_NONE          3'h7
`define ID_FIRST          21'h200000
`define ID_LAST           21'h200007
`define ID_IDX_W          3
`define GUARD_ALL_ONES    5'h1f
`define DBG_RSV_BASE      21'h007e00
`define DBG_STACK_LVLS    5'h02
`define DBG_DATA_BYTES    8'h0a
`define ZERO_BYTE         8'h00

`endif

// *** verilog/code_protect_and_prog_port.v ***
/*
 Protection gate between program/data-EEPROM/ID storage and its two
 requesters: CPU table operations and the external serial programmer.
 Assumes the storage arrays sit outside; this block decides per access
 and returns the data the requester is allowed to see. Pins arrive
 asynchronously and are filtered; CPU side is on the same clock.
*/
// How it works
// - Block read guard only blocks programmer accesses, never CPU execution.
// - Cleared block write guard refuses CPU table writes into that block.
// - Cleared table read guard still lets code in that block read it.
// - Table reads from outside a guarded block return zero.
// - Guard bits only go one to zero; writing one over zero is ignored.
// - Guards return to one only by chip or block erase from programmer.
// - EEPROM read guard blocks programmer reads and writes of EEPROM.
// - EEPROM write guard blocks CPU and programmer EEPROM writes.
// - Config write guard is CPU read-only; programmer alone may change it.
// - Eight ID bytes stay readable and writable, even when guarded.
// - Debug bit zero enables the debugger, one keeps it off.
// - Debugger reserves two stack levels, 512 program bytes, 10 data, pins.
// - Alternate port bit enables three alternate pins acting like legacy.
// - Legacy port stays usable; legacy programming level masks alternate level pin.
// - Alternate port bit writable except during alternate port high voltage entry.
// - Emulation select low disables extra ports, parallel port, enhanced PWM.
// - Emulation select matters only with debugger on and alternate port on.
// - Single supply bit set makes entry pin a mode control, not I/O.
// - High voltage entry always accepted regardless of single supply bit.
// - Single supply bit changes only in high voltage mode; cleared means only that.
// - Unprotected memory erases by row or block; protected only by block.
// - Boot block of 2 Kbytes plus four blocks, each with own guards.
`timescale 1ns/1ps
`include "code_protect_map.vh"
`default_nettype none

module code_protect_and_prog_port (
   input  wire                 clock,
   input  wire                 rst,
   // Legacy and alternate programming pins (asynchronous)
   input  wire                 reset_vpp_level_pin,
   input  wire                 reset_prog_voltage_pin,
   input  wire                 prog_entry_pin,
   input  wire                 alt_reset_prog_pin,
   input  wire                 alt_vpp_level_pin,
   input  wire                 emulation_select_pin,
   // CPU table access (same clock)
   input  wire                 cpu_req,
   input  wire                 cpu_write,
   input  wire                 cpu_eeprom,
   input  wire [`ADDR_W-1:0]   cpu_fetch_addr,
   input  wire [`ADDR_W-1:0]   cpu_target_addr,
   input  wire [7:0]           cpu_wdata,
   // Programmer request (decoded from serial link by the port logic)
   input  wire                 prog_req,
   input  wire                 prog_write,
   input  wire                 prog_eeprom,
   input  wire                 prog_erase_block,
   input  wire                 prog_erase_chip,
   input  wire                 prog_erase_row,
   input  wire                 prog_cfg_write,
   input  wire [`ADDR_W-1:0]   prog_addr,
   input  wire [7:0]           prog_wdata,
   input  wire [4:0]           cfg_wr_read_guard,
   input  wire [4:0]           cfg_wr_write_guard,
   input  wire [4:0]           cfg_wr_table_guard,
   input  wire                 cfg_wr_eeprom_read,
   input  wire                 cfg_wr_eeprom_write,
   input  wire                 cfg_wr_config_write,
   input  wire                 cfg_wr_debug,
   input  wire                 cfg_wr_alt_port,
   input  wire                 cfg_wr_single_supply,
   // Storage read data
   input  wire [7:0]           mem_rdata,
   // Storage strobes
   output reg                  mem_read,
   output reg                  mem_write,
   output reg                  mem_erase_row,
   output reg                  mem_erase_block,
   output reg  [`ADDR_W-1:0]   mem_addr,
   output reg  [7:0]           mem_wdata,
   output reg                  mem_eeprom,
   output reg  [2:0]           erase_blk,
   output reg                  cpu_ack,
   output reg                  cpu_refused,
   output reg  [7:0]           cpu_rdata,
   output reg                  prog_ack,
   output reg                  prog_refused,
   output reg  [7:0]           prog_rdata,
   // Configuration state
   output reg  [4:0]           block_read_guard,
   output reg  [4:0]           block_write_guard,
   output reg  [4:0]           block_table_read_guard,
   output reg                  eeprom_read_guard,
   output reg                  eeprom_write_guard,
   output reg                  config_write_guard,
   output reg                  debug_bit,
   output reg                  alt_port_enable_bit,
   output reg                  single_supply_prog_enable,
   // Derived modes
   output reg                  prog_mode,
   output reg                  alt_port_enable,
   output reg                  debugger_enabled,
   output reg  [4:0]           dbg_stack_reserved,
   output reg  [`ADDR_W-1:0]   dbg_prog_reserve_base,
   output reg  [7:0]           dbg_data_reserved,
   output reg                  dbg_pins_reserved,
   output reg                  entry_pin_is_gpio,
   output reg                  extra_ports_enable
);

   // Three-stage pin filters; a level counts when stages two and three agree
   localparam NPIN = 6;
   wire [NPIN-1:0] pin_raw = {emulation_select_pin, alt_vpp_level_pin, alt_reset_prog_pin,
                              prog_entry_pin, reset_prog_voltage_pin, reset_vpp_level_pin};
   // Filters reset low; idle-high pins settle within four edges
   reg  [NPIN-1:0] s1_q;
   reg  [NPIN-1:0] s2_q;
   reg  [NPIN-1:0] s3_q;
   reg  [NPIN-1:0] pin_q;
   genvar g;
   generate
      for (g = 0; g < NPIN; g = g + 1) begin : g_sync
         always @(posedge clock) begin
            if (rst) begin
               s1_q[g]  <= 1'b0;
               s2_q[g]  <= 1'b0;
               s3_q[g]  <= 1'b0;
               pin_q[g] <= 1'b0;
            end else begin
               s1_q[g] <= pin_raw[g];
               s2_q[g] <= s1_q[g];
               s3_q[g] <= s2_q[g];
               if (s2_q[g] == s3_q[g])
                  pin_q[g] <= s3_q[g];
            end
         end
      end
   endgenerate

   wire vpp_legacy  = pin_q[0];   // Elevated programming level on legacy reset
   wire rst_legacy  = pin_q[1];   // Legacy reset pin at normal supply
   wire entry_pin   = pin_q[2];
   wire rst_alt     = pin_q[3];   // Alternate reset pin at normal supply
   wire vpp_alt     = pin_q[4];
   wire emul_sel    = pin_q[5];

   // Legacy level masks the alternate level pin for high-voltage entry only
   wire hv_alt      = alt_port_enable_bit & ~vpp_legacy & vpp_alt;
   wire hv_entry    = vpp_legacy | hv_alt;
   // Legacy reset pin, or alternate one when alternate port bit set, at supply qualifies single-supply entry
   wire rst_any     = rst_legacy | (alt_port_enable_bit & rst_alt);
   wire lv_entry    = single_supply_prog_enable & rst_any & entry_pin;
   wire entering    = hv_entry | lv_entry;

   // Block lookup, purely combinational so decision lands same cycle
   function [2:0] blk_of;
      input [`ADDR_W-1:0] a;
      begin
         if (a <= `BOOT_END)
            blk_of = 3'h0;
         else if (a <= `BLK0_END)
            blk_of = 3'h1;
         else if (a <= `BLK1_END)
            blk_of = 3'h2;
         else if (a <= `BLK2_END)
            blk_of = 3'h3;
         else if (a <= `BLK3_END)
            blk_of = 3'h4;
         else
            blk_of = `BLK_NONE;
      end
   endfunction

   wire [2:0] cpu_tblk  = blk_of(cpu_target_addr);
   wire [2:0] cpu_fblk  = blk_of(cpu_fetch_addr);
   wire [2:0] prog_blk  = blk_of(prog_addr);
   wire       cpu_in    = (cpu_tblk != `BLK_NONE);
   wire       prog_in   = (prog_blk != `BLK_NONE);
   wire       cpu_id    = (cpu_target_addr >= `ID_FIRST) && (cpu_target_addr <= `ID_LAST);
   wire       prog_id   = (prog_addr >= `ID_FIRST) && (prog_addr <= `ID_LAST);

   wire cpu_wr_ok  = cpu_eeprom ? eeprom_write_guard
                   : cpu_id ? 1'b1
                   : ~cpu_in | block_write_guard[cpu_tblk];
   // Table read guard is bypassed when fetching from the same block
   wire cpu_rd_ok  = cpu_eeprom | cpu_id | ~cpu_in
                   | block_table_read_guard[cpu_tblk]
                   | (cpu_fblk == cpu_tblk);
   // Block read guard never consulted for CPU accesses

   wire prog_rd_ok = prog_eeprom ? eeprom_read_guard
                   : prog_id ? 1'b1
                   : ~prog_in | block_read_guard[prog_blk];
   wire prog_wr_ok = prog_eeprom ? (eeprom_read_guard & eeprom_write_guard)
                   : prog_id ? 1'b1
                   : ~prog_in | (block_read_guard[prog_blk] & block_write_guard[prog_blk]);
   // Row erase refused on a read-guarded block; block erase always allowed
   wire row_ok     = ~prog_in | block_read_guard[prog_blk];

   wire cpu_fire   = cpu_req & ~prog_mode;
   // CPU and programmer never share a cycle: prog_mode splits them
   wire prog_fire  = prog_req & prog_mode;
   wire cfg_fire   = prog_fire & prog_cfg_write;
   // Config write wins, so no erase rides along with one
   wire op_fire    = prog_fire & ~prog_cfg_write;

   always @(posedge clock) begin
      if (rst) begin
         prog_mode <= 1'b0;
         mem_read <= 1'b0;
         mem_write <= 1'b0;
         mem_erase_row <= 1'b0;
         mem_erase_block <= 1'b0;
         mem_addr <= {`ADDR_W{1'b0}};
         mem_wdata <= `ZERO_BYTE;
         mem_eeprom <= 1'b0;
         erase_blk <= 3'h0;
         cpu_ack <= 1'b0;
         cpu_refused <= 1'b0;
         cpu_rdata <= `ZERO_BYTE;
         prog_ack <= 1'b0;
         prog_refused <= 1'b0;
         prog_rdata <= `ZERO_BYTE;
      end else begin
         prog_mode <= entering;
         mem_read <= 1'b0;
         mem_write <= 1'b0;
         mem_erase_row <= 1'b0;
         mem_erase_block <= 1'b0;
         cpu_ack <= 1'b0;
         cpu_refused <= 1'b0;
         prog_ack <= 1'b0;
         prog_refused <= 1'b0;
         // Read data is gated combinationally from the same-cycle decision
         cpu_rdata <= (cpu_fire & ~cpu_write & cpu_rd_ok) ? mem_rdata : `ZERO_BYTE;
         prog_rdata <= (prog_fire & ~prog_write & prog_rd_ok) ? mem_rdata : `ZERO_BYTE;
         if (cpu_fire) begin
            cpu_ack <= 1'b1;
            mem_addr <= cpu_target_addr;
            mem_wdata <= cpu_wdata;
            mem_eeprom <= cpu_eeprom;
            if (cpu_write) begin
               mem_write <= cpu_wr_ok;
               cpu_refused <= ~cpu_wr_ok;
            end else begin
               mem_read <= 1'b1;
            end
         end else if (op_fire) begin
            prog_ack <= 1'b1;
            mem_addr <= prog_addr;
            mem_wdata <= prog_wdata;
            mem_eeprom <= prog_eeprom;
            erase_blk <= prog_blk;
            if (prog_erase_chip | prog_erase_block) begin
               mem_erase_block <= 1'b1;
            end else if (prog_erase_row) begin
               mem_erase_row <= row_ok;
               prog_refused <= ~row_ok;
            end else if (prog_write) begin
               mem_write <= prog_wr_ok;
               prog_refused <= ~prog_wr_ok;
            end else begin
               mem_read <= 1'b1;
               prog_refused <= ~prog_rd_ok;
            end
         end else if (cfg_fire) begin
            prog_ack <= 1'b1;
            prog_refused <= ~config_write_guard;
         end
      end
   end

   // Guard bits erase to one and otherwise only fall
   always @(posedge clock) begin
      if (rst) begin
         block_read_guard <= `GUARD_ALL_ONES;
         block_write_guard <= `GUARD_ALL_ONES;
         block_table_read_guard <= `GUARD_ALL_ONES;
         eeprom_read_guard <= 1'b1;
         eeprom_write_guard <= 1'b1;
         config_write_guard <= 1'b1;
         debug_bit <= 1'b1;
         alt_port_enable_bit <= 1'b0;
         single_supply_prog_enable <= 1'b1;
      end else if (op_fire & prog_erase_chip) begin
         // Debug, port and supply bits stay as programmed
         block_read_guard <= `GUARD_ALL_ONES;
         block_write_guard <= `GUARD_ALL_ONES;
         block_table_read_guard <= `GUARD_ALL_ONES;
         eeprom_read_guard <= 1'b1;
         eeprom_write_guard <= 1'b1;
         config_write_guard <= 1'b1;
      end else if (op_fire & prog_erase_block & prog_in) begin
         block_read_guard[prog_blk] <= 1'b1;
         block_write_guard[prog_blk] <= 1'b1;
         block_table_read_guard[prog_blk] <= 1'b1;
      end else if (cfg_fire & config_write_guard) begin
         // AND with current value: a one never revives a zero
         block_read_guard <= block_read_guard & cfg_wr_read_guard;
         block_write_guard <= block_write_guard & cfg_wr_write_guard;
         block_table_read_guard <= block_table_read_guard & cfg_wr_table_guard;
         eeprom_read_guard <= eeprom_read_guard & cfg_wr_eeprom_read;
         eeprom_write_guard <= eeprom_write_guard & cfg_wr_eeprom_write;
         config_write_guard <= config_write_guard & cfg_wr_config_write;
         debug_bit <= cfg_wr_debug;
         if (~hv_alt)
            alt_port_enable_bit <= cfg_wr_alt_port;
         if (hv_entry)
            single_supply_prog_enable <= cfg_wr_single_supply;
      end
   end

   // Derived modes, registered so every output comes from a flip-flop
   wire dbg_on = ~debug_bit;
   wire emul_active = dbg_on & alt_port_enable_bit;
   // Reservations are fixed sizes, owned by the debugger while enabled
   always @(posedge clock) begin
      if (rst) begin
         alt_port_enable <= 1'b0;
         debugger_enabled <= 1'b0;
         dbg_stack_reserved <= 5'h00;
         dbg_prog_reserve_base <= {`ADDR_W{1'b0}};
         dbg_data_reserved <= `ZERO_BYTE;
         dbg_pins_reserved <= 1'b0;
         entry_pin_is_gpio <= 1'b1;
         extra_ports_enable <= 1'b1;
      end else begin
         alt_port_enable <= alt_port_enable_bit;
         debugger_enabled <= dbg_on;
         dbg_stack_reserved <= dbg_on ? `DBG_STACK_LVLS : 5'h00;
         dbg_prog_reserve_base <= dbg_on ? `DBG_RSV_BASE : {`ADDR_W{1'b0}};
         dbg_data_reserved <= dbg_on ? `DBG_DATA_BYTES : `ZERO_BYTE;
         dbg_pins_reserved <= dbg_on;
         entry_pin_is_gpio <= ~single_supply_prog_enable;
         extra_ports_enable <= ~emul_active | emul_sel;
      end
   end

endmodule // code_protect_and_prog_port

`default_nettype wire

// *** tb/cp_checker.sv ***
/* Port-level checker for the protection block, bound into it.
   Assumes one clock domain and the block's synchronous reset. */
`timescale 1ns/1ps
`include "code_protect_map.vh"
`default_nettype none
module cp_checker (
   input wire logic               clock, rst, prog_mode, cpu_req, cpu_write, cpu_eeprom,
   input wire logic [`ADDR_W-1:0] cpu_fetch_addr, cpu_target_addr, prog_addr,
   input wire logic               prog_req, prog_erase_chip, prog_erase_block, prog_erase_row,
   input wire logic               cpu_ack, cpu_refused, mem_write, mem_erase_row, prog_ack,
   input wire logic               prog_refused, eeprom_write_guard, config_write_guard,
   input wire logic [7:0]         cpu_rdata,
   input wire logic [4:0]         block_read_guard, block_write_guard, block_table_read_guard
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   function automatic int bi(input logic [`ADDR_W-1:0] a);
      return a <= `BOOT_END ? 0 : a <= `BLK0_END ? 1 : a <= `BLK1_END ? 2 :
             a <= `BLK2_END ? 3 : a <= `BLK3_END ? 4 : 7;
   endfunction
   // Outside the five blocks nothing is guarded
   function automatic logic gd(input logic [4:0] v, input logic [`ADDR_W-1:0] a);
      return bi(a) < 5 && !v[bi(a)];
   endfunction
   wire cpu_take = cpu_req && !prog_mode;
   wire prog_take = prog_req && prog_mode;
   cpu_answer_a: assert property (cpu_take |=> cpu_ack)
      else $error("cpu request not answered");
   cpu_ignore_a: assert property (cpu_req && prog_mode |=> !cpu_ack)
      else $error("cpu served in programming mode");
   prog_answer_a: assert property (prog_take |=> prog_ack)
      else $error("programmer request not answered");
   table_zero_a: assert property (cpu_take && !cpu_write && !cpu_eeprom &&
      gd(block_table_read_guard, cpu_target_addr) && bi(cpu_fetch_addr) != bi(cpu_target_addr)
      |=> cpu_rdata == `ZERO_BYTE) else $error("guarded table read leaked data");
   write_refuse_a: assert property (cpu_take && cpu_write && !cpu_eeprom &&
      gd(block_write_guard, cpu_target_addr) |=> cpu_refused && !mem_write)
      else $error("guarded table write accepted");
   eeprom_lock_a: assert property (cpu_take && cpu_write && cpu_eeprom && !eeprom_write_guard
      |=> cpu_refused && !mem_write) else $error("guarded eeprom write accepted");
   guard_rise_a: assert property (!$past(rst) &&
      !$past(prog_take && (prog_erase_chip || prog_erase_block))
      |-> (block_read_guard & ~$past(block_read_guard)) == 5'h00) else $error("guard rose");
   row_keep_a: assert property (prog_take && prog_erase_row && gd(block_read_guard, prog_addr)
      |=> !mem_erase_row && prog_refused) else $error("protected row erased");
   cfg_hold_a: assert property (!$past(rst) && $changed(config_write_guard) |-> $past(prog_take))
      else $error("config guard changed without programmer");
   cover property (cpu_take && cpu_write ##1 cpu_refused);
   cover property (prog_take && prog_erase_chip);
   cover property (cpu_take && gd(block_table_read_guard, cpu_target_addr));
endmodule // cp_checker
bind code_protect_and_prog_port cp_checker u_cp_checker (.*);
`default_nettype wire

// *** tb/prog_partner.sv ***
/* Behavioural external programmer: entry pins and request lines.
   Assumes the bench calls its tasks and judges the device's answers. */
`timescale 1ns/1ps
`default_nettype none
module prog_partner (
   input  wire logic   clock,
   output logic        reset_vpp_level_pin, reset_prog_voltage_pin, prog_entry_pin, prog_req,
   output logic        prog_write, prog_eeprom, prog_erase_block, prog_erase_chip,
   output logic        prog_erase_row, prog_cfg_write,
   output logic [20:0] prog_addr,
   output logic [7:0]  prog_wdata
);
   initial begin
      {reset_vpp_level_pin, prog_entry_pin, prog_req, prog_addr, prog_wdata} = 32'h00000000;
      {prog_write, prog_eeprom, prog_erase_block, prog_erase_chip, prog_erase_row} = 5'h00;
      prog_cfg_write = 1'b0;
      reset_prog_voltage_pin = 1'b1; // Held at supply before any entry
   end
   task automatic enter(input logic hv);
      @(posedge clock) #1;
      if (hv) reset_vpp_level_pin = 1'b1;
      else prog_entry_pin = 1'b1;
   endtask
   task automatic leave();
      @(posedge clock) #1;
      {reset_vpp_level_pin, prog_entry_pin} = 2'h0;
   endtask
   // Kind bits: write, eeprom, block erase, chip erase, row erase, config write
   task automatic op(input logic [5:0] k, input logic [20:0] a, input logic [7:0] d);
      @(posedge clock) #1;
      prog_req = 1'b1;
      {prog_write, prog_eeprom, prog_erase_block, prog_erase_chip, prog_erase_row} = k[5:1];
      prog_cfg_write = k[0];
      prog_addr = a;
      prog_wdata = d;
      @(posedge clock) #1;
      {prog_req, prog_write, prog_eeprom, prog_erase_block, prog_erase_chip} = 5'h00;
      {prog_erase_row, prog_cfg_write} = 2'h0;
      // Released lines must not keep the last value
      prog_addr = ~a;
      prog_wdata = ~d;
   endtask
endmodule // prog_partner
`default_nettype wire

// *** tb/code_protect_and_prog_port_tb_top.sv ***
/* Self-checking bench for the protection block with a programmer model.
   Assumes storage is modelled by driving mem_rdata from here. */
`timescale 1ns/1ps
`include "code_protect_map.vh"
`default_nettype none
module code_protect_and_prog_port_tb_top;
   logic        clock, rst, alt_reset_prog_pin, alt_vpp_level_pin, emulation_select_pin, ewg;
   logic        cpu_req, cpu_write, cpu_eeprom;
   logic [20:0] cpu_fetch_addr, cpu_target_addr, cv;
   logic [7:0]  cpu_wdata, mem_rdata;
   logic [4:0]  rg, wg, tg;
   wire [4:0]   cfg_wr_read_guard, cfg_wr_write_guard, cfg_wr_table_guard;
   wire         cfg_wr_eeprom_read, cfg_wr_eeprom_write, cfg_wr_config_write, cfg_wr_debug;
   wire         cfg_wr_alt_port, cfg_wr_single_supply, debug_bit, alt_port_enable_bit;
   wire         reset_vpp_level_pin, reset_prog_voltage_pin, prog_entry_pin, prog_req;
   wire         prog_write, prog_eeprom, prog_erase_block, prog_erase_chip, prog_erase_row;
   wire         prog_cfg_write, mem_read, mem_write, mem_erase_row, mem_erase_block;
   wire         mem_eeprom, cpu_ack, cpu_refused, prog_ack, prog_refused, eeprom_read_guard;
   wire         eeprom_write_guard, config_write_guard, single_supply_prog_enable, prog_mode;
   wire         alt_port_enable, debugger_enabled, dbg_pins_reserved, entry_pin_is_gpio;
   wire         extra_ports_enable;
   wire [20:0]  prog_addr, mem_addr, dbg_prog_reserve_base;
   wire [7:0]   prog_wdata, mem_wdata, cpu_rdata, prog_rdata, dbg_data_reserved;
   wire [4:0]   block_read_guard, block_write_guard, block_table_read_guard, dbg_stack_reserved;
   wire [2:0]   erase_blk;
   logic [20:0] lo [6] = '{21'h000000, 21'h000800, 21'h002000, 21'h004000, 21'h006000, `ID_FIRST};
   logic [20:0] hi [6] = '{`BOOT_END, `BLK0_END, `BLK1_END, `BLK2_END, `BLK3_END, `ID_LAST};
   logic [5:0]  pk [6] = '{6'h00, 6'h00, 6'h10, 6'h30, 6'h02, 6'h02};
   logic [20:0] pa [6] = '{21'h000900, 21'h006100, 21'h000010, 21'h000010, 21'h000900, 21'h006100};
   logic        pr [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
   int          num_errors = 0, num_checks = 0, cyc = 0;
   assign {cfg_wr_read_guard, cfg_wr_write_guard, cfg_wr_table_guard, cfg_wr_eeprom_read,
           cfg_wr_eeprom_write, cfg_wr_config_write, cfg_wr_debug, cfg_wr_alt_port,
           cfg_wr_single_supply} = cv;
   code_protect_and_prog_port u_code_protect_and_prog_port (.*);
   prog_partner u_prog_partner (.*);
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (s !== e) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", n, e, s);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d, errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   function automatic int blk(input logic [20:0] a);
      for (int i = 0; i < 5; i++) if (a <= hi[i]) return i;
      return 7;
   endfunction
   function automatic logic [20:0] ra(input int n);
      int k, r;
      k = $urandom % n;
      r = $urandom % 3;
      return r == 0 ? lo[k] : r == 1 ? hi[k] : lo[k] + 21'($urandom % (hi[k] - lo[k] + 1));
   endfunction
   task automatic wait_mode(input logic m);
      for (int i = 0; i < 20 && prog_mode !== m; i++) @(posedge clock) #1;
   endtask
   task automatic cpu(input logic w, input logic e, input logic [20:0] f, input logic [20:0] t);
      int b;
      logic [7:0] d;
      logic x;
      b = blk(t);
      d = 8'($urandom);
      x = w && (e ? !ewg : b < 5 && !wg[b]);
      @(posedge clock) #1;
      {cpu_req, cpu_write, cpu_eeprom, cpu_fetch_addr, cpu_target_addr} = {1'b1, w, e, f, t};
      {cpu_wdata, mem_rdata} = {~d, d};
      @(posedge clock) #1;
      {cpu_req, mem_rdata} = {1'b0, ~d};
      chk("cpu_ack", 1'b1, cpu_ack);
      if (w) chk("refused,write", {x, !x}, {cpu_refused, mem_write});
      else chk("cpu_rdata", !e && b < 5 && !tg[b] && blk(f) != b ? 8'h00 : d, cpu_rdata);
      chk("mem_addr,read,eeprom", {t, !w, e}, {mem_addr, mem_read, mem_eeprom});
      chk("mem_wdata", {~d}, mem_wdata);
   endtask
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // Whole run is well under a thousand cycles
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         end_sim();
      end
   end
   initial begin
      rst = 1'b1;
      {alt_reset_prog_pin, alt_vpp_level_pin, cpu_req, cpu_write, cpu_eeprom} = 5'h00;
      {cpu_fetch_addr, cpu_target_addr, cpu_wdata, mem_rdata} = 58'h0;
      {emulation_select_pin, rg, wg, tg, ewg, cv} = {1'b1, 16'hffff, 21'h1fffff};
      void'($urandom(32'h379e));
      repeat (10) @(posedge clock);
      #1 rst = 1'b0;
      chk("reset state", 20'hffffd, {block_read_guard, block_write_guard, block_table_read_guard,
          eeprom_write_guard, config_write_guard, debug_bit, alt_port_enable_bit,
          single_supply_prog_enable});
      repeat (20) cpu($urandom % 2, $urandom % 4 == 0, ra(5), ra(6));
      u_prog_partner.enter(1'b0);
      wait_mode(1'b1);
      chk("single supply entry", 2'h2, {prog_mode, entry_pin_is_gpio});
      u_prog_partner.leave();
      wait_mode(1'b0);
      u_prog_partner.enter(1'b1);
      wait_mode(1'b1);
      chk("prog_mode", 1'b1, prog_mode);
      cv = {5'h1d, 5'h1b, 5'h17, 6'h0a};
      u_prog_partner.op(6'h01, 21'h000000, 8'h00);
      cv = {15'h7fff, 6'h32};
      u_prog_partner.op(6'h01, 21'h000000, 8'h00);
      {rg, wg, tg, ewg} = {5'h1d, 5'h1b, 5'h17, 1'b0};
      chk("guards", {rg, wg, tg, ewg, 2'h0}, {block_read_guard, block_write_guard,
          block_table_read_guard, eeprom_write_guard, eeprom_read_guard,
          config_write_guard});
      for (int i = 0; i < 6; i++) begin
         mem_rdata = 8'h5a;
         u_prog_partner.op(pk[i], pa[i], 8'ha5);
         chk("prog_refused", pr[i], prog_refused);
         chk("mem_addr", pa[i], mem_addr);
         if (pk[i] == 6'h02) chk("mem_erase_row", !pr[i], mem_erase_row);
         else if (!pk[i][5]) chk("prog_rdata", pr[i] ? 8'h00 : 8'h5a, prog_rdata);
      end
      @(posedge clock) #1 cpu_req = 1'b1;
      @(posedge clock) #1 cpu_req = 1'b0;
      chk("cpu_ack", 1'b0, cpu_ack);
      u_prog_partner.leave();
      wait_mode(1'b0);
      chk("debug", {5'h1f, `DBG_STACK_LVLS, `DBG_DATA_BYTES}, {debugger_enabled, dbg_pins_reserved,
          alt_port_enable, entry_pin_is_gpio, extra_ports_enable, dbg_stack_reserved,
          dbg_data_reserved});
      chk("reserve base", `DBG_RSV_BASE, dbg_prog_reserve_base);
      alt_vpp_level_pin = 1'b1;
      wait_mode(1'b1);
      chk("alt port entry", 1'b1, prog_mode);
      alt_vpp_level_pin = 1'b0;
      wait_mode(1'b0);
      emulation_select_pin = 1'b0;
      repeat (8) @(posedge clock);
      chk("extra_ports_enable", 1'b0, extra_ports_enable);
      u_prog_partner.enter(1'b0);
      repeat (10) @(posedge clock);
      chk("prog_mode", 1'b0, prog_mode);
      u_prog_partner.leave();
      repeat (200) cpu($urandom % 2, $urandom % 4 == 0, ra(5), ra(6));
      u_prog_partner.enter(1'b1);
      wait_mode(1'b1);
      cv = 21'h000000;
      u_prog_partner.op(6'h01, 21'h000000, 8'h00);
      chk("locked config", {5'h1d, 1'b1}, {block_read_guard, prog_refused});
      u_prog_partner.op(6'h08, 21'h000900, 8'h00);
      chk("block erase", {5'h1f, 3'h1, 1'b1},
          {block_read_guard, erase_blk, mem_erase_block});
      u_prog_partner.op(6'h04, 21'h000000, 8'h00);
      {rg, wg, tg, ewg} = 16'hffff;
      chk("erased guards", 18'h3ffff, {block_read_guard, block_write_guard,
          block_table_read_guard, eeprom_write_guard, config_write_guard,
          mem_erase_block});
      u_prog_partner.leave();
      wait_mode(1'b0);
      repeat (20) cpu($urandom % 2, $urandom % 4 == 0, ra(5), ra(6));
      end_sim();
   end
endmodule // code_protect_and_prog_port_tb_top
`default_nettype wire
